//--- rtl/mac_hs_pkg.sv
// Constants and types for the five-signal serial link access handshake (slave end).
// Assumes a 100 MHz system clock and a master that drives the link clock.
package mac_hs_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 10;
  localparam int REQ_PULSE_NS        = 1000;
  localparam int REQ_PULSE_CYCLES    = (REQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PREP_NS             = 40;
  localparam int PREP_CYCLES         = (PREP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] READY_TIME_NS  = 16'h07d0;
  localparam logic [15:0] RESUME_TIME_NS = 16'h2710;
  localparam logic [7:0]  PULSE_CNT_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Link framing
  // ----------------------------------------------------------------------
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_PULSE = 5'b00010,
    ST_PREP  = 5'b00100,
    ST_WAIT  = 5'b01000,
    ST_XFER  = 5'b10000
  } mac_state_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rx_event_type;

  typedef struct packed {
    logic [15:0] ready_time_ns;
    logic [15:0] resume_time_ns;
  } ready_report_type;

endpackage

//--- rtl/mac_hs_slave.sv
// Slave end of the five-signal serial link access handshake and mode 0 shifter.
// Assumes the master drives select and link clock and senses the request edge.
//
// Summary of operation
// R1: Advertise ready time covering worst-case delay
// R2: Master waits ready time before transfer
// R3: Request pulse lasts at least one microsecond
// R4: Master senses request on leading edge
// R5: Report resume time for power saving
// R6: Master waits resume time when saving
// R7: Master selects, waits, clocks, then releases
// R8: Master skips wait only if impossible
// R9: Request only while select seen high
// R10: One request pulse of request width
// R11: After pulse, prepare serial block, await
// R12: Master answers request after ready time
// R13: Simultaneous start: still pulse, then await
// R14: Preparation fits ready minus pulse time
// R15: Master activation: float, clock low, power
// R16: Master deactivation: float, clock low, off
// R17: Clock mode zero, sample rising edges
// R18: Select low means asserted
// R19: Synchronise inputs, count pulse from clock
// R20: Master times waits with programmable counter
`timescale 1ns/1ps
module mac_hs_slave (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       link_clk,
  input  wire logic                       slave_select_n,
  input  wire logic                       mosi,
  output logic                            miso,
  output logic                            miso_oe,
  output logic                            slave_request_irq,
  input  wire logic                       access_req,
  input  wire logic                       power_save,
  input  wire logic [7:0]                 tx_byte,
  output mac_hs_pkg::rx_event_type        rx_event,
  output logic                            xfer_done,
  output logic                            serial_enable,
  output logic                            busy,
  output mac_hs_pkg::ready_report_type    ready_control_message
);
  import mac_hs_pkg::*;

  // ----------------------------------------------------------------------
  // Link domain: mode 0 shifter
  // ----------------------------------------------------------------------
  logic [7:0] rx_shift;
  logic [7:0] rx_hold;
  logic [2:0] rx_cnt;
  logic       rx_toggle;
  logic [7:0] tx_shift;
  logic [2:0] tx_cnt;
  logic       tx_first;

  // Release of select ends the frame; the link clock may stop any time
  always_ff @(posedge link_clk or posedge slave_select_n) begin
    if (slave_select_n) begin // R18
      rx_cnt   <= 3'h0;
      rx_shift <= 8'h00;
    end else begin
      rx_shift <= {rx_shift[6:0], mosi}; // R17
      rx_cnt   <= rx_cnt + 3'h1;
    end
  end

  // Byte hold and toggle survive frame end so the last byte is not lost
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_hold   <= 8'h00;
      rx_toggle <= 1'b0;
    end else if (!slave_select_n && rx_cnt == LAST_BIT) begin
      rx_hold   <= {rx_shift[6:0], mosi};
      rx_toggle <= ~rx_toggle;
    end
  end

  // Async clear loads constants only; each byte's first bit comes from tx_byte,
  // which is quasi-static, so it stands before the first rising edge
  always_ff @(negedge link_clk or posedge slave_select_n) begin
    if (slave_select_n) begin
      tx_shift <= 8'h00;
      tx_cnt   <= 3'h0;
      tx_first <= 1'b1;
    end else begin
      tx_cnt   <= tx_cnt + 3'h1;
      tx_first <= (tx_cnt == LAST_BIT);
      if (tx_first) begin
        tx_shift <= {tx_byte[6:0], 1'b0}; // R17
      end else begin
        tx_shift <= {tx_shift[6:0], 1'b0}; // R17
      end
    end
  end

  assign miso = tx_first ? tx_byte[7] : tx_shift[7];

  // ----------------------------------------------------------------------
  // Crossing into the system domain
  // ----------------------------------------------------------------------
  logic [1:0] synced;
  logic       sel_high;
  logic       tog_sync;
  logic       tog_seen;

  mac_hs_sync u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({slave_select_n, rx_toggle}),
    .sync_out (synced)
  ); // R19

  assign sel_high = synced[1];
  assign tog_sync = synced[0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tog_seen <= 1'b0;
    end else begin
      tog_seen <= tog_sync;
    end
  end

  // ----------------------------------------------------------------------
  // Access handshake state machine
  // ----------------------------------------------------------------------
  mac_state_type state;
  mac_state_type next_state;
  logic [7:0]    pulse_cnt;
  logic          pending;
  logic          start_pulse;

  assign start_pulse = (state == ST_IDLE) && pending && sel_high; // R9

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_pulse) begin
          next_state = ST_PULSE;
        end else if (!sel_high) begin
          next_state = ST_XFER;
        end
      end
      // Master selecting mid-pulse does not cut the pulse short
      ST_PULSE: begin
        if (pulse_cnt == 8'(REQ_PULSE_CYCLES - 1)) begin // R3 R10 R13
          next_state = ST_PREP;
        end
      end
      ST_PREP: begin
        if (pulse_cnt == 8'(PREP_CYCLES - 1)) begin // R11 R14
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!sel_high) begin
          next_state = ST_XFER;
        end
      end
      ST_XFER: begin
        if (sel_high) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_cnt <= PULSE_CNT_RESET;
    end else if (next_state != state) begin
      pulse_cnt <= PULSE_CNT_RESET;
    end else begin
      pulse_cnt <= pulse_cnt + 8'h01; // R19
    end
  end

  // New request wins over the clear that starts a pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pending <= 1'b0;
    end else if (access_req) begin
      pending <= 1'b1;
    end else if (start_pulse) begin
      pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slave_request_irq <= 1'b0;
      serial_enable     <= 1'b1;
      miso_oe           <= 1'b0;
      busy              <= 1'b0;
      xfer_done         <= 1'b0;
    end else begin
      slave_request_irq <= (next_state == ST_PULSE); // R10
      // Serial block held off while requesting so it never self-selects
      serial_enable     <= (next_state != ST_PULSE) && (next_state != ST_PREP); // R11
      miso_oe           <= !sel_high && (next_state != ST_PULSE) && (next_state != ST_PREP);
      busy              <= (next_state != ST_IDLE) || pending;
      xfer_done         <= (state == ST_XFER) && sel_high;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_event <= '0;
    end else begin
      rx_event.valid <= (tog_sync != tog_seen) && serial_enable;
      if (tog_sync != tog_seen) begin
        rx_event.data <= rx_hold;
      end
    end
  end

  // Values advertised at initialisation; resume covers power saving wake-up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ready_control_message.ready_time_ns  <= READY_TIME_NS; // R1
      ready_control_message.resume_time_ns <= RESUME_TIME_NS; // R5
    end else begin
      ready_control_message.ready_time_ns  <= READY_TIME_NS;
      ready_control_message.resume_time_ns <= power_save ? RESUME_TIME_NS : RESUME_TIME_NS;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_PULSE_WIDTH: assert property (@(posedge clk) disable iff (!rst_n) // R3, checked over the first 8 cycles only (80 ns), not the full microsecond
    $rose(slave_request_irq) |-> slave_request_irq [*8] ##0 (pulse_cnt >= 8'h07))
    else $error("request pulse too short");

  AST_PULSE_LEN: assert property (@(posedge clk) disable iff (!rst_n) // R10
    $rose(slave_request_irq) |-> ##[99:100] $fell(slave_request_irq))
    else $error("request pulse length wrong");

  AST_SEL_HIGH: assert property (@(posedge clk) disable iff (!rst_n) // R9
    $rose(slave_request_irq) |-> $past(sel_high))
    else $error("request started while selected");

  AST_PREP_AFTER: assert property (@(posedge clk) disable iff (!rst_n) // R11
    $fell(slave_request_irq) |-> !serial_enable ##[1:5] serial_enable)
    else $error("serial block not prepared after pulse");

  AST_OFF_DURING: assert property (@(posedge clk) disable iff (!rst_n) // R11
    slave_request_irq |-> !serial_enable)
    else $error("serial block enabled during request");

  AST_SIMULT: assert property (@(posedge clk) disable iff (!rst_n) // R13
    (state == ST_PULSE && !sel_high) |=> (state == ST_PULSE || state == ST_PREP))
    else $error("pulse aborted by master select");

  AST_FIT: assert property (@(posedge clk) disable iff (!rst_n) // R14
    $fell(slave_request_irq) |-> ##[1:8] serial_enable)
    else $error("preparation overruns ready time");

  AST_READY: assert property (@(posedge clk) disable iff (!rst_n) // R1
    ready_control_message.ready_time_ns >= 16'(REQ_PULSE_NS + PREP_NS + 4 * CLK_PERIOD_NS))
    else $error("ready time too small");

  AST_OE: assert property (@(posedge clk) disable iff (!rst_n) // R18
    (sel_high && $past(sel_high)) |=> !miso_oe)
    else $error("driving data while released");

  AST_SYNC: assert property (@(posedge clk) disable iff (!rst_n) // R19
    (state == ST_WAIT && !sel_high) |=> state == ST_XFER)
    else $error("synced select not followed");

endmodule

//--- rtl/mac_hs_sync.sv
// Two-flop synchroniser for two single-bit levels.
// Assumes the inputs come from another clock domain or from pins.
`timescale 1ns/1ps
module mac_hs_sync (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);

  logic [1:0] meta;

  // Reset to the idle levels (select high, toggle low) so no false edge follows
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta     <= 2'h2;
      sync_out <= 2'h2;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

//--- testbench/spi_host_model.sv
// Behavioural host master for the five-signal access handshake.
// Assumes the slave drives miso in mode 0 and pulses its request line.
`timescale 1ns/1ps
module spi_host_model (
  output logic      link_clk,
  output logic      slave_select_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic slave_request_irq
);
  // ----------------------------------------------------------------------
  // Request sensing and frames
  // ----------------------------------------------------------------------
  int irq_edges;

  // Idle: clock low, select released, as after activation
  initial begin
    link_clk       = 1'b0;
    slave_select_n = 1'b1;
    mosi           = 1'b0;
    irq_edges      = 0;
  end

  // Leading edge only, a held level is not a new request
  always @(posedge slave_request_irq) irq_edges++;

  // Select, settle, clock eight bits MSB first, stop clock, release
  task automatic frame(input logic [7:0] tx, input int wait_ns, output logic [7:0] rx);
    slave_select_n = 1'b0;
    #(wait_ns);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #3 link_clk = 1'b1;
      rx[i] = miso;
      #3 link_clk = 1'b0;
    end
    // Line stays no longer valid once the frame ends
    mosi = ~mosi;
    #10 slave_select_n = 1'b1;
  endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for the slave access handshake.
// Assumes the host model in its own file and the design package.
`timescale 1ns/1ps
module tb;
  import mac_hs_pkg::*;
  // ----------------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------------
  logic             clk, rst_n, access_req, power_save;
  logic [7:0]       tx_byte;
  logic             link_clk, slave_select_n, mosi, miso, miso_oe, irq;
  logic             xfer_done, serial_enable, busy;
  rx_event_type     rx_event;
  ready_report_type rep;
  logic [7:0]       rx_last;
  int               rx_cnt, done_cnt, err_total, comparisons;

  mac_hs_slave DUT (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
    .slave_select_n(slave_select_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .slave_request_irq(irq), .access_req(access_req), .power_save(power_save),
    .tx_byte(tx_byte), .rx_event(rx_event), .xfer_done(xfer_done),
    .serial_enable(serial_enable), .busy(busy), .ready_control_message(rep));

  spi_host_model host (.link_clk(link_clk), .slave_select_n(slave_select_n),
    .mosi(mosi), .miso(miso), .slave_request_irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rx_cnt   = 0;
    done_cnt = 0;
  end
  always @(negedge clk) begin
    if (rx_event.valid === 1'b1) begin
      rx_cnt++;
      rx_last = rx_event.data;
    end
    if (xfer_done === 1'b1) done_cnt++;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    comparisons++;
    if (got !== ex) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    chk("irq", 16'h0, {15'h0, irq});
    chk("oe", 16'h0, {15'h0, miso_oe});
    chk("sen", 16'h1, {15'h0, serial_enable});
    chk("busy", 16'h0, {15'h0, busy});
    chk("ready", READY_TIME_NS, rep.ready_time_ns);
    chk("resume", RESUME_TIME_NS, rep.resume_time_ns);
    chk("cover", 16'h1, {15'h0, rep.ready_time_ns >= 16'(REQ_PULSE_NS + PREP_NS)});
  endtask

  // Host-initiated frame; the settle time is chosen by the caller
  task automatic t_master(input logic [7:0] a, input logic [7:0] b, input int w);
    logic [7:0] got;
    int         n0, d0;
    tx_byte = b;
    n0 = rx_cnt;
    d0 = done_cnt;
    host.frame(a, w, got);
    repeat (8) @(negedge clk);
    chk("rx count", 16'h1, 16'(rx_cnt - n0));
    chk("rx data", {8'h0, a}, {8'h0, rx_last});
    chk("miso", {8'h0, b}, {8'h0, got});
    chk("done", 16'h1, 16'(done_cnt - d0));
    chk("oe off", 16'h0, {15'h0, miso_oe});
    chk("busy", 16'h0, {15'h0, busy});
  endtask

  // Request pulse, preparation, then the host answers it
  task automatic t_req(input bit raise);
    int n, m, bad, e0;
    e0 = host.irq_edges;
    if (raise) begin
      access_req = 1'b1;
      @(negedge clk);
      access_req = 1'b0;
    end
    for (n = 0; n < 300 && irq !== 1'b1; n++) @(negedge clk);
    n   = 0;
    bad = 0;
    while (irq === 1'b1 && n < 200) begin
      n++;
      if (serial_enable !== 1'b0) bad++;
      @(negedge clk);
    end
    chk("pulse len", 16'(REQ_PULSE_CYCLES), 16'(n));
    chk("sen low", 16'h0, 16'(bad));
    m = 0;
    while (serial_enable !== 1'b1 && m < 50) begin
      m++;
      @(negedge clk);
    end
    chk("prep", 16'(PREP_CYCLES), 16'(m));
    chk("one edge", 16'h1, 16'(host.irq_edges - e0));
    // Wait out the rest of the ready time from the leading edge
    #1000;
    t_master(8'h3c, 8'ha5, 2000);
  endtask

  // A request raised while selected must wait for the release
  task automatic t_block;
    logic [7:0] got;
    int         e0;
    e0 = host.irq_edges;
    tx_byte = 8'h81;
    fork
      host.frame(8'h5a, 2000, got);
      begin
        #500;
        @(negedge clk);
        access_req = 1'b1;
        @(negedge clk);
        access_req = 1'b0;
      end
    join
    chk("held", 16'h0, 16'(host.irq_edges - e0));
    chk("miso", 16'h81, {8'h0, got});
    t_req(1'b0);
  endtask

  // ----------------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    rst_n       = 1'b0;
    access_req  = 1'b0;
    power_save  = 1'b0;
    tx_byte     = 8'h00;
    err_total   = 0;
    comparisons = 0;
    repeat (4) @(negedge clk);
    t_reset;
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_master(8'hc3, 8'h96, 2000);
    t_req(1'b1);
    t_block;
    power_save = 1'b1;
    t_master(8'h0f, 8'hf0, 10000);
    wrap_up;
  end

  // Whole run needs well under 60 us
  initial begin
    #400000;
    err_total++;
    wrap_up;
  end
endmodule
